// *** one_wire_tx_pkg.sv ***
`default_nettype none
package one_wire_tx_pkg;
  // Clock rate of ref_clk.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // Pulse widths that do not depend on the antenna resonance.
  localparam int unsigned ON_DELAY_US = 64;
  localparam int unsigned ACK_US = 256;
  localparam int unsigned ERR_US = 128;
  localparam int unsigned DEBOUNCE_US = 20;
  localparam int unsigned ON_DELAY_CYC = (ON_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACK_CYC = (ACK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ERR_CYC = (ERR_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Low timeout in microseconds; a plain default that a system may tune.
  localparam int unsigned LOW_TIMEOUT_US = 100_000;
  localparam int unsigned LOW_TIMEOUT_CYC = LOW_TIMEOUT_US / 1000 * (CLK_HZ / 1000);
  // Counts in antenna cycles: high timeout is 16 ms at the nominal 125 kHz.
  localparam int unsigned HIGH_TIMEOUT_MS = 16;
  localparam int unsigned ANT_NOMINAL_HZ = 125_000;
  localparam int unsigned HIGH_TIMEOUT_ANT = HIGH_TIMEOUT_MS * ANT_NOMINAL_HZ / 1000;
  localparam int unsigned OFF_DELAY_ANT = 8;
  localparam int unsigned FAULT_WINDOW_ANT = 16;
  localparam int unsigned CNT_W = 24;
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_STANDBY = 6'h02,
    ST_TRANSMIT = 6'h04,
    ST_HOLD_LOW = 6'h08,
    ST_ANSWER = 6'h10,
    ST_WAIT_HIGH = 6'h20
  } mode_t;
endpackage : one_wire_tx_pkg
`default_nettype wire

// *** one_wire_transmit_controller.sv ***
`default_nettype none
// Contract
// - After reset, settle into standby once the line is sensed high.
// - In standby only line receiver lives; a low line wakes into transmit.
// - High means pulled to selected level, low means pulled to ground.
// - Line low beyond low timeout turns driver off and returns to standby.
// - After high timeout and answer pulse, enter standby.
// - Low line drives antenna square wave; high line holds output at ground.
// - Driver enables only after line low continuously for the on-delay.
// - Driver disables only after line high for off-delay in antenna cycles; hard failure or low timeout drop it at once.
// - Timeout supervisor: its low-timeout counter counts only while the line is low; its high-timeout counter counts while the line is high.
// - No failure after high timeout: pull line low for 256 us.
// - Recorded failure: pull line low for 128 us instead.
// - Hard failures stop driver at once; soft failures only mark the answer.
// - Failures are evaluated over a window counted in antenna cycles; hard failures use the 20 us debounce in reference clock cycles.
// - High timeout is counted in antenna cycles.
// - Answer pulse lengths are counted in reference clock cycles.
// - All logic runs on one clock; antenna rate is an enable pulse.
// - Between transmit end and answer, keep the low-side switch on.
// - A protection shutdown puts both half-bridge switches high-impedance.
// - Protection causes debounce 20 us, filter active only while bridge enabled.
module one_wire_transmit_controller #(
  parameter int unsigned LOW_TIMEOUT_CYC = one_wire_tx_pkg::LOW_TIMEOUT_CYC,
  parameter int unsigned HIGH_TIMEOUT_ANT = one_wire_tx_pkg::HIGH_TIMEOUT_ANT,
  parameter int unsigned OFF_DELAY_ANT = one_wire_tx_pkg::OFF_DELAY_ANT,
  parameter int unsigned FAULT_WINDOW_ANT = one_wire_tx_pkg::FAULT_WINDOW_ANT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic oneWireLineIn,
  output logic oneWireLineOut,
  output logic oneWireLineOe_n,
  input wire logic lineLevelSelect,
  input wire logic antennaTick,
  input wire logic protectFault,
  input wire logic diagFault,
  output logic antennaDriveOut,
  output logic highSideOn,
  output logic lowSideOn,
  output logic bridgeTristate,
  output logic standby,
  output logic levelBattery
);
  localparam logic [23:0] ON_CYC = 24'(one_wire_tx_pkg::ON_DELAY_CYC);
  localparam logic [23:0] ACK_CYC = 24'(one_wire_tx_pkg::ACK_CYC);
  localparam logic [23:0] ERR_CYC = 24'(one_wire_tx_pkg::ERR_CYC);
  localparam logic [23:0] DEB_CYC = 24'(one_wire_tx_pkg::DEBOUNCE_CYC);
  localparam logic [23:0] LOW_CYC = 24'(LOW_TIMEOUT_CYC);
  localparam logic [23:0] HIGH_ANT = 24'(HIGH_TIMEOUT_ANT);
  localparam logic [23:0] OFF_ANT = 24'(OFF_DELAY_ANT);
  localparam logic [23:0] WIN_ANT = 24'(FAULT_WINDOW_ANT);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [1:0] lineSync_q, tickSync_q, protSync_q, diagSync_q, selSync_q;
  logic tickPrev_q;
  logic lineLow, antEn;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lineSync_q <= 2'h3;
      tickSync_q <= 2'h0;
      protSync_q <= 2'h0;
      diagSync_q <= 2'h0;
      selSync_q <= 2'h0;
      tickPrev_q <= 1'b0;
    end else begin
      lineSync_q <= {lineSync_q[0], oneWireLineIn};
      tickSync_q <= {tickSync_q[0], antennaTick};
      protSync_q <= {protSync_q[0], protectFault};
      diagSync_q <= {diagSync_q[0], diagFault};
      selSync_q <= {selSync_q[0], lineLevelSelect};
      tickPrev_q <= tickSync_q[1];
    end
  end
  // The resolved wire is already a logic level; the selected level only sets the receiver threshold.
  assign lineLow = ~lineSync_q[1];
  // The antenna clock arrives as a tracking tick; its rising edge is the antenna-rate enable.
  assign antEn = tickSync_q[1] & ~tickPrev_q;
  assign levelBattery = selSync_q[1];

  // ==========================================================
  // Mode machine
  // ==========================================================
  one_wire_tx_pkg::mode_t mode_q;
  logic [23:0] lowCnt_q, onCnt_q, offCnt_q, highCnt_q, ansCnt_q, debCnt_q, winCnt_q;
  logic driveOn_q, failSoft_q, failHard_q, errAns_q, ansDone;
  logic lowTimeout, highTimeout;
  assign lowTimeout = lowCnt_q >= LOW_CYC;
  assign highTimeout = highCnt_q >= HIGH_ANT;
  assign ansDone = ansCnt_q >= (errAns_q ? ERR_CYC : ACK_CYC);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= one_wire_tx_pkg::ST_RESET;
    end else begin
      case (mode_q)
        one_wire_tx_pkg::ST_RESET: begin
          if (!lineLow) mode_q <= one_wire_tx_pkg::ST_STANDBY;
        end
        one_wire_tx_pkg::ST_STANDBY: begin
          if (lineLow) mode_q <= one_wire_tx_pkg::ST_TRANSMIT;
        end
        one_wire_tx_pkg::ST_TRANSMIT: begin
          if (lowTimeout) mode_q <= one_wire_tx_pkg::ST_WAIT_HIGH;
          else if (highTimeout) mode_q <= one_wire_tx_pkg::ST_HOLD_LOW;
        end
        one_wire_tx_pkg::ST_HOLD_LOW: mode_q <= one_wire_tx_pkg::ST_ANSWER;
        // Our own answer pulse still reads as low through the synchroniser, so wait for the release.
        one_wire_tx_pkg::ST_ANSWER: begin
          if (ansDone) mode_q <= one_wire_tx_pkg::ST_WAIT_HIGH;
        end
        // A stuck-low line would wake again at once; wait for a release first.
        one_wire_tx_pkg::ST_WAIT_HIGH: begin
          if (!lineLow) mode_q <= one_wire_tx_pkg::ST_STANDBY;
        end
        default: mode_q <= one_wire_tx_pkg::ST_RESET;
      endcase
    end
  end
  assign standby = mode_q != one_wire_tx_pkg::ST_TRANSMIT &&
                   mode_q != one_wire_tx_pkg::ST_HOLD_LOW && mode_q != one_wire_tx_pkg::ST_ANSWER;

  // ==========================================================
  // Timeout supervisor
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt_q <= 24'h0;
    end else if (mode_q != one_wire_tx_pkg::ST_TRANSMIT || !lineLow) begin
      lowCnt_q <= 24'h0;
    end else if (!lowTimeout) begin
      lowCnt_q <= lowCnt_q + 24'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      highCnt_q <= 24'h0;
    end else if (mode_q != one_wire_tx_pkg::ST_TRANSMIT || lineLow) begin
      highCnt_q <= 24'h0;
    end else if (antEn && !highTimeout) begin
      highCnt_q <= highCnt_q + 24'h1;
    end
  end

  // ==========================================================
  // Anti-bounce driver gate
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      onCnt_q <= 24'h0;
      offCnt_q <= 24'h0;
      driveOn_q <= 1'b0;
    end else if (mode_q != one_wire_tx_pkg::ST_TRANSMIT || lowTimeout || failHard_q) begin
      onCnt_q <= 24'h0;
      offCnt_q <= 24'h0;
      driveOn_q <= 1'b0;
    end else if (lineLow) begin
      offCnt_q <= 24'h0;
      if (onCnt_q >= ON_CYC - 24'h1) driveOn_q <= 1'b1;
      else onCnt_q <= onCnt_q + 24'h1;
    end else begin
      onCnt_q <= 24'h0;
      if (antEn) begin
        if (offCnt_q >= OFF_ANT - 24'h1) driveOn_q <= 1'b0;
        else offCnt_q <= offCnt_q + 24'h1;
      end
    end
  end

  // ==========================================================
  // Failure handling
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      debCnt_q <= 24'h0;
      failHard_q <= 1'b0;
    end else if (mode_q == one_wire_tx_pkg::ST_STANDBY) begin
      debCnt_q <= 24'h0;
      failHard_q <= 1'b0;
    end else if (protSync_q[1] && (driveOn_q || mode_q == one_wire_tx_pkg::ST_HOLD_LOW)) begin
      if (debCnt_q >= DEB_CYC - 24'h1) failHard_q <= 1'b1;
      else debCnt_q <= debCnt_q + 24'h1;
    end else if (!failHard_q) begin
      debCnt_q <= 24'h0;
    end
  end
  // Diagnosis is sampled on every antenna tick while driving; one high sample flags failSoft_q at the window end.
  logic diagSeen_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      winCnt_q <= 24'h0;
      diagSeen_q <= 1'b0;
      failSoft_q <= 1'b0;
    end else if (mode_q == one_wire_tx_pkg::ST_STANDBY) begin
      winCnt_q <= 24'h0;
      diagSeen_q <= 1'b0;
      failSoft_q <= 1'b0;
    end else if (driveOn_q && antEn) begin
      diagSeen_q <= diagSeen_q | diagSync_q[1];
      if (winCnt_q >= WIN_ANT - 24'h1) begin
        winCnt_q <= 24'h0;
        failSoft_q <= failSoft_q | diagSeen_q | diagSync_q[1];
        diagSeen_q <= 1'b0;
      end else begin
        winCnt_q <= winCnt_q + 24'h1;
      end
    end
  end

  // ==========================================================
  // Answer pulse
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ansCnt_q <= 24'h0;
      errAns_q <= 1'b0;
    end else if (mode_q == one_wire_tx_pkg::ST_HOLD_LOW) begin
      ansCnt_q <= 24'h0;
      errAns_q <= failSoft_q | failHard_q;
    end else if (mode_q == one_wire_tx_pkg::ST_ANSWER) begin
      ansCnt_q <= ansCnt_q + 24'h1;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic sqWave_q, lineOut_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sqWave_q <= 1'b0;
      lineOut_q <= 1'b0;
      antennaDriveOut <= 1'b0;
      highSideOn <= 1'b0;
      lowSideOn <= 1'b0;
      bridgeTristate <= 1'b1;
    end else begin
      if (antEn) sqWave_q <= ~sqWave_q;
      lineOut_q <= mode_q == one_wire_tx_pkg::ST_ANSWER && !ansDone;
      antennaDriveOut <= driveOn_q & sqWave_q & ~failHard_q;
      highSideOn <= driveOn_q & sqWave_q & ~failHard_q;
      lowSideOn <= ~failHard_q & ~standby & ~(driveOn_q & sqWave_q);
      bridgeTristate <= failHard_q | standby;
    end
  end
  assign oneWireLineOut = 1'b0;
  assign oneWireLineOe_n = ~lineOut_q;

  // ==========================================================
  // Checks
  // ==========================================================
  a_ack_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(mode_q == one_wire_tx_pkg::ST_ANSWER) && !errAns_q |-> !ansDone [*8]) else $error("ack too short");
  a_err_pick: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_HOLD_LOW && failSoft_q |=> errAns_q) else $error("error pulse not chosen");
  a_only_pull: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !oneWireLineOe_n |-> oneWireLineOut == 1'b0) else $error("line driven high");
  a_high_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !lineLow [*2] ##1 !lineLow |-> lowCnt_q == 24'h0) else $error("timeout counts while high");
  a_on_delay: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(driveOn_q) |-> $past(lineLow) && $past(lineLow, 2)) else $error("driver on without low");
  // Once back in standby the hard fault is cleared on purpose, so only the active modes are watched.
  a_trip_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    failHard_q && !standby |-> ##2 bridgeTristate && !antennaDriveOut) else $error("no shutdown");
  a_standby_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    standby |-> ##2 !antennaDriveOut) else $error("drive in standby");
  a_wake_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_STANDBY && lineLow |=> mode_q == one_wire_tx_pkg::ST_TRANSMIT)
    else $error("no wake");
  a_low_trip: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_TRANSMIT && lowTimeout |=> !driveOn_q && mode_q == one_wire_tx_pkg::ST_WAIT_HIGH)
    else $error("low timeout ignored");
  a_reset_settle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_RESET && !lineLow |=> mode_q == one_wire_tx_pkg::ST_STANDBY)
    else $error("no standby after reset");
  a_hold_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_TRANSMIT && driveOn_q && lineLow && !lowTimeout && !failHard_q |=> driveOn_q)
    else $error("driver dropped while low");
  a_tick_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    highCnt_q != $past(highCnt_q) && highCnt_q != 24'h0 |-> $past(antEn))
    else $error("high timeout off the antenna rate");
  a_side_split: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(highSideOn && lowSideOn)) else $error("both switches on");
  a_low_side: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_HOLD_LOW && !failHard_q && !driveOn_q |=> lowSideOn)
    else $error("low side off before answer");
  a_answer_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_ANSWER && !ansDone |=> !oneWireLineOe_n)
    else $error("answer pulse released early");
  a_fault_debounce: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(failHard_q) |-> $past(protSync_q[1]) && $past(debCnt_q) == DEB_CYC - 24'h1)
    else $error("fault not debounced");
  a_soft_window: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(failSoft_q) |-> $past(winCnt_q) == WIN_ANT - 24'h1)
    else $error("soft failure off the window");
  c_answer: cover property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_ANSWER && ansDone);
  c_drive: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(driveOn_q));
  c_trip: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(failHard_q));
  c_error: cover property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_ANSWER && errAns_q && ansDone);
  c_refresh: cover property (@(posedge ref_clk) disable iff (!reset_n)
    mode_q == one_wire_tx_pkg::ST_TRANSMIT && lowCnt_q != 24'h0 ##1 lowCnt_q == 24'h0 && !standby);
endmodule : one_wire_transmit_controller
`default_nettype wire

// *** one_wire_host_model.sv ***
`default_nettype none
// ==========================================================================
// Far-side controller: pulls the shared wire and times the device's answer.
module one_wire_host_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hostPull,
  input wire logic devOe_n,
  output logic lineLevel,
  output int answerCount,
  output int answerWidth
);
  timeunit 1ns;
  timeprecision 100ps;
  int run;
  // The pull-up wins unless some party pulls the wire to ground.
  assign lineLevel = !(hostPull || (devOe_n === 1'b0));
  // The controller only measures while the device answers, so width tells ack from error.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 0;
      answerCount <= 0;
      answerWidth <= 0;
    end else if (devOe_n === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      answerWidth <= run;
      answerCount <= answerCount + 1;
      run <= 0;
    end
  end
endmodule : one_wire_host_model
`default_nettype wire

// *** one_wire_transmit_controller_tb.sv ***
`default_nettype none
module one_wire_transmit_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOW_CYC = 5000;
  localparam int HIGH_ANT = 20;
  localparam int OFF_ANT = 8;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b1;
  logic hostPull = 1'b0;
  logic lineLevelSelect = 1'b0;
  logic antennaTick = 1'b0;
  logic protectFault = 1'b0;
  logic diagFault = 1'b0;
  logic [2:0] tickDiv = 3'h0;
  logic lineLevel, oneWireLineOut, oneWireLineOe_n, antennaDriveOut, prevDrive;
  logic highSideOn, lowSideOn, bridgeTristate, standby, levelBattery;
  int answerCount, answerWidth, toggles, t0, mismatches, compares;
  int expQ[$];
  always #12.5 ref_clk = ~ref_clk;
  // ========================================================================
  // Antenna tick: one rising edge every 8 reference cycles.
  always @(posedge ref_clk) begin
    tickDiv <= tickDiv + 3'h1;
    antennaTick <= tickDiv[2];
    prevDrive <= antennaDriveOut;
    if (antennaDriveOut !== prevDrive) toggles <= toggles + 1;
  end
  one_wire_transmit_controller #(.LOW_TIMEOUT_CYC(LOW_CYC), .HIGH_TIMEOUT_ANT(HIGH_ANT),
    .OFF_DELAY_ANT(OFF_ANT), .FAULT_WINDOW_ANT(16)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .oneWireLineIn(lineLevel), .oneWireLineOut(oneWireLineOut),
    .oneWireLineOe_n(oneWireLineOe_n), .lineLevelSelect(lineLevelSelect), .antennaTick(antennaTick),
    .protectFault(protectFault), .diagFault(diagFault), .antennaDriveOut(antennaDriveOut),
    .highSideOn(highSideOn), .lowSideOn(lowSideOn), .bridgeTristate(bridgeTristate),
    .standby(standby), .levelBattery(levelBattery));
  one_wire_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .hostPull(hostPull),
    .devOe_n(oneWireLineOe_n), .lineLevel(lineLevel), .answerCount(answerCount), .answerWidth(answerWidth));
  // ========================================================================
  // Shared tasks.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : check
  task automatic pull(input logic v);
    @(posedge ref_clk);
    hostPull <= v;
  endtask : pull
  // The line is left released so the high timeout can run out and the answer can start.
  task automatic wait_answer();
    int n;
    int lim;
    n = answerCount;
    lim = 0;
    pull(1'b0);
    while (answerCount == n && lim < HIGH_ANT * 8 + 16000) begin
      cyc(1);
      lim++;
    end
    check(32'(answerWidth), 32'(expQ.pop_front()), "answer width");
    cyc(5);
    check(standby, 1'b1, "standby after answer");
  endtask : wait_answer
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    cyc(90000);
    mismatches++;
    wrap_up();
  end
  // ========================================================================
  // Main sequence.
  initial begin
    int i;
    void'($urandom(46217));
    // Reset falls by a scheduled assignment so that the asynchronous reset sees a real edge at time zero.
    reset_n <= 1'b0;
    toggles = 0;
    cyc(12);
    reset_n <= 1'b1;
    lineLevelSelect <= 1'($urandom % 2);
    cyc(10);
    check(standby, 1'b1, "standby after reset");
    check(oneWireLineOe_n, 1'b1, "released after reset");
    check(levelBattery, lineLevelSelect, "level select");
    $display("test reset done");
    expQ.push_back(one_wire_tx_pkg::ACK_CYC);
    pull(1'b1);
    t0 = toggles;
    cyc(10);
    check(standby, 1'b0, "wake on low");
    cyc(2400);
    check(32'(toggles - t0), 32'h0, "drive before on-delay");
    cyc(300 + $urandom % 400);
    check(32'(toggles > t0), 32'h1, "drive after on-delay");
    pull(1'b0);
    cyc(20);
    pull(1'b1);
    t0 = toggles;
    cyc(40);
    check(32'(toggles > t0), 32'h1, "short high filtered");
    pull(1'b0);
    cyc(OFF_ANT * 8 + 40);
    t0 = toggles;
    cyc(50);
    check(32'(toggles - t0), 32'h0, "drive stopped");
    check(antennaDriveOut, 1'b0, "drive at ground");
    check(lowSideOn, 1'b1, "low side holds ground");
    check(highSideOn, 1'b0, "high side off when idle");
    wait_answer();
    $display("test ack done");
    expQ.push_back(one_wire_tx_pkg::ERR_CYC);
    pull(1'b1);
    cyc(2800);
    diagFault <= 1'b1;
    cyc(16 * 8 * 2);
    diagFault <= 1'b0;
    cyc(100);
    wait_answer();
    $display("test diag error done");
    expQ.push_back(one_wire_tx_pkg::ERR_CYC);
    pull(1'b1);
    cyc(2800);
    protectFault <= 1'b1;
    cyc(100);
    protectFault <= 1'b0;
    cyc(10);
    check(bridgeTristate, 1'b0, "short fault debounced");
    protectFault <= 1'b1;
    cyc(one_wire_tx_pkg::DEBOUNCE_CYC + 40);
    protectFault <= 1'b0;
    check(bridgeTristate, 1'b1, "bridge off after fault");
    check(lowSideOn, 1'b0, "low side open after fault");
    check(highSideOn, 1'b0, "high side open after fault");
    t0 = toggles;
    cyc(30);
    check(32'(toggles - t0), 32'h0, "no drive after fault");
    wait_answer();
    $display("test protection done");
    pull(1'b1);
    for (i = 0; i < 2; i++) begin
      cyc(4000);
      pull(1'b0);
      cyc(10);
      pull(1'b1);
    end
    check(standby, 1'b0, "refresh keeps transmit");
    cyc(LOW_CYC + 200);
    check(standby, 1'b1, "low timeout");
    t0 = toggles;
    cyc(30);
    check(32'(toggles - t0), 32'h0, "driver off after timeout");
    pull(1'b0);
    cyc(HIGH_ANT * 8 + 12000);
    check(oneWireLineOe_n, 1'b1, "line released at end");
    check(oneWireLineOut, 1'b0, "line only pulled low");
    $display("test timeout done");
    wrap_up();
  end
endmodule : one_wire_transmit_controller_tb
`default_nettype wire
